// >>> include/cms_pkg.sv
package cms_pkg;

  typedef logic [11:0] cms_val_t;

  // register byte addresses
  localparam logic [7:0] CMS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] CMS_ADDR_TOOTH  = 8'h04;
  localparam logic [7:0] CMS_ADDR_STATUS = 8'h08;
  localparam logic [7:0] CMS_ADDR_PON_THR = 8'h0c;

  // control field positions
  localparam int CMS_CTRL_POL      = 0;
  localparam int CMS_CTRL_HYS_LSB  = 1;
  localparam int CMS_CTRL_OPT_LSB  = 3;
  localparam int CMS_CTRL_BOUNDED  = 5;
  localparam int CMS_CTRL_AUTO_THR = 6;

  // tooth register field positions
  localparam int CMS_TOOTH_POS_LSB   = 0;
  localparam int CMS_TOOTH_MEM_LSB   = 4;
  localparam int CMS_TOOTH_SLOPE_LSB = 8;
  localparam int CMS_TOOTH_LEVEL_LSB = 16;

  // status field positions
  localparam int CMS_STAT_MODE_LSB  = 0;
  localparam int CMS_STAT_TOOTH     = 2;
  localparam int CMS_STAT_OUT       = 3;
  localparam int CMS_STAT_WRITTEN   = 4;
  localparam int CMS_STAT_PEAKS_LSB = 8;
  localparam int CMS_STAT_WDOG_LSB  = 16;

  // reset values of the writable fields
  localparam logic       CMS_RST_POL      = 1'b1;
  localparam logic [1:0] CMS_RST_HYS      = 2'h0;
  localparam logic [1:0] CMS_RST_OPT      = 2'h0;
  localparam logic       CMS_RST_BOUNDED  = 1'b0;
  localparam logic       CMS_RST_AUTO_THR = 1'b1;
  localparam logic [3:0] CMS_RST_POS_N    = 4'h1;
  localparam logic [3:0] CMS_RST_MEM_N    = 4'h1;
  localparam logic [7:0] CMS_RST_SLOPE    = 8'h00;
  localparam logic [7:0] CMS_RST_LEVEL    = 8'h80;

  // hysteresis select codes and fractions of the span, in 1/256
  localparam logic [1:0] CMS_HYS_15 = 2'h0;
  localparam logic [1:0] CMS_HYS_10 = 2'h1;
  localparam logic [1:0] CMS_HYS_20 = 2'h2;
  localparam logic [1:0] CMS_HYS_30 = 2'h3;
  localparam logic [7:0] CMS_FRAC_15 = 8'h26;
  localparam logic [7:0] CMS_FRAC_10 = 8'h1a;
  localparam logic [7:0] CMS_FRAC_20 = 8'h33;
  localparam logic [7:0] CMS_FRAC_30 = 8'h4d;

  // power-on to running transition options
  localparam logic [1:0] CMS_OPT_RAPID     = 2'h0;
  localparam logic [1:0] CMS_OPT_QUALIFIED = 2'h1;
  localparam logic [1:0] CMS_OPT_MEMORY    = 2'h2;

  localparam logic [3:0] CMS_QUAL_EDGES = 4'h2;
  localparam logic [3:0] CMS_POS_N_MAX  = 4'hd;
  localparam logic [3:0] CMS_MEM_N_MAX  = 4'hc;
  localparam cms_val_t   CMS_STARTUP_HYST = 12'h040;
  localparam cms_val_t   CMS_THR_DELTA    = 12'h080;
  localparam logic [7:0] CMS_LEVEL_MAX    = 8'hf0;
  localparam int         CMS_BOUND_SHIFT  = 2;

  // watchdog stall time
  localparam int CMS_CLK_MHZ      = 200;
  localparam int CMS_WDOG_TIME_MS = 100;
  localparam int CMS_WDOG_CYCLES  = CMS_WDOG_TIME_MS * 1000 * CMS_CLK_MHZ;

  typedef enum logic [1:0] {
    CMS_MODE_POWER_ON = 2'b00,
    CMS_MODE_CALIB    = 2'b01,
    CMS_MODE_RUNNING  = 2'b11
  } cms_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cms_apb_req_t;

  typedef struct packed {
    logic     valid;
    cms_val_t value;
  } cms_sample_t;

  typedef struct packed {
    logic     strobe;
    cms_val_t data;
  } cms_nvm_wr_t;

  typedef struct packed {
    logic                  polarity;
    logic [1:0]            hys_sel;
    logic [1:0]            opt;
    logic                  bounded;
    logic                  auto_thr;
    logic [3:0]            pos_n;
    logic [3:0]            mem_n;
    logic [7:0]            slope;
    logic [7:0]            level;
    logic [31:0]           rdata;
    cms_mode_t             mode;
    logic                  tooth;
    logic                  out_pin;
    logic                  first;
    logic                  thr_loaded;
    logic                  thr_written;
    cms_val_t              pon_thr;
    cms_nvm_wr_t           nvm;
    cms_val_t              cur_max;
    cms_val_t              cur_min;
    cms_val_t              po_max;
    cms_val_t              po_min;
    logic [12:0][11:0]     peaks;
    cms_val_t              valley;
    logic [3:0]            peak_cnt;
    logic [3:0]            edge_cnt;
    logic [24:0]           wdog_cnt;
    logic [7:0]            wdog_fires;
  } cms_state_t;

  localparam cms_state_t CMS_STATE_RESET = '{
    polarity: CMS_RST_POL, hys_sel: CMS_RST_HYS, opt: CMS_RST_OPT,
    bounded: CMS_RST_BOUNDED, auto_thr: CMS_RST_AUTO_THR,
    pos_n: CMS_RST_POS_N, mem_n: CMS_RST_MEM_N, slope: CMS_RST_SLOPE,
    level: CMS_RST_LEVEL, mode: CMS_MODE_POWER_ON, first: 1'b1,
    default: '0
  };

endpackage

// >>> src/cms_mode_sequencer.sv
// Behaviour
// - classic fixed switch level used only when slope setting is zero
// - nonzero slope selects dynamic level that follows the signal span
// - hidden hysteresis defaults to 15 percent; 10, 20, 30 selectable
// - hysteresis applies symmetrically to rising and falling transitions
// - after power-on output compares field against power-on threshold
// - power-on mode duration depends on rapid, qualified or memory option
// - rapid: movement beyond startup hysteresis enters calibration mode
// - qualified: at least two output edges before running mode
// - memory: stay for programmed 1..12 teeth before running mode
// - first power-up uses factory threshold held in nonvolatile memory
// - large midpoint difference rewrites threshold into nonvolatile memory
// - calibration switches with continuous previous-tooth threshold update
// - calibration ends when enough peaks fill memory; then running
// - running thresholds from update setting, switch method and hysteresis
// - peak tracking plus stalled output triggers the watchdog
// - watchdog self-resets block back to startup hysteresis mode
// - output polarity selectable low or high opposite a tooth
// - positive peak reference taken from 1..13 teeth earlier
// - continuous valley option uses previous tooth's valley
// - bounded valley option discards large tooth-to-tooth valley jumps
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module cms_mode_sequencer
  import cms_pkg::*;
#(
  parameter int WDOG_CYCLES = CMS_WDOG_CYCLES
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire cms_apb_req_t apb_req,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire cms_sample_t  sample,
  input  wire cms_val_t     nvm_pon_thr,
  output cms_nvm_wr_t       nvm_wr,
  output logic              tooth_out
);

  localparam logic [24:0] WDOG_LIMIT = 25'(WDOG_CYCLES - 1);

  function automatic cms_val_t frac_of(input cms_val_t span,
                                       input logic [7:0] frac);
    logic [19:0] prod;
    prod = span * frac;
    return prod[19:8];
  endfunction

  function automatic logic [7:0] hyst_frac(input logic [1:0] sel);
    logic [7:0] f;
    unique case (sel)
      CMS_HYS_10: f = CMS_FRAC_10;
      CMS_HYS_20: f = CMS_FRAC_20;
      CMS_HYS_30: f = CMS_FRAC_30;
      default:    f = CMS_FRAC_15;
    endcase
    return f;
  endfunction

  function automatic cms_val_t sat_diff(input cms_val_t a,
                                        input cms_val_t b);
    return (a > b) ? cms_val_t'(a - b) : '0;
  endfunction

  function automatic logic [3:0] clamp_n(input logic [3:0] v,
                                         input logic [3:0] hi);
    if (v == 4'h0) begin
      return 4'h1;
    end
    return (v > hi) ? hi : v;
  endfunction

  cms_state_t  r;
  cms_state_t  n;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  cms_val_t    s;
  cms_val_t    pk_ref;
  cms_val_t    span;
  cms_val_t    thr;
  cms_val_t    half_hys;
  cms_val_t    rise_thr;
  cms_val_t    fall_thr;
  cms_val_t    mid;
  cms_val_t    new_valley;
  cms_val_t    dyn_add;
  logic [8:0]  lvl_sum;
  logic [7:0]  level_use;
  logic        rise_edge;
  logic        fall_edge;
  logic        moving;
  logic        wdog_fire;
  logic [3:0]  pk_idx;

  always_comb begin
    mapped = (apb_req.paddr == CMS_ADDR_CTRL)
          || (apb_req.paddr == CMS_ADDR_TOOTH)
          || (apb_req.paddr == CMS_ADDR_STATUS)
          || (apb_req.paddr == CMS_ADDR_PON_THR);
  end

  // no wait states: read data is latched in the setup cycle
  assign pready  = apb_req.psel & apb_req.penable;
  assign pslverr = pready & ~mapped;
  assign prdata  = r.rdata;
  assign nvm_wr  = r.nvm;
  assign tooth_out = r.out_pin;

  always_comb begin
    n = r;
    wr_en    = pready & apb_req.pwrite & mapped;
    rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    s        = sample.value;
    n.nvm.strobe = 1'b0;

    // register writes steer the sequencer
    if (wr_en && apb_req.paddr == CMS_ADDR_CTRL) begin
      n.polarity = apb_req.pwdata[CMS_CTRL_POL];
      n.hys_sel  = apb_req.pwdata[CMS_CTRL_HYS_LSB +: 2];
      n.opt      = apb_req.pwdata[CMS_CTRL_OPT_LSB +: 2];
      n.bounded  = apb_req.pwdata[CMS_CTRL_BOUNDED];
      n.auto_thr = apb_req.pwdata[CMS_CTRL_AUTO_THR];
    end
    if (wr_en && apb_req.paddr == CMS_ADDR_TOOTH) begin
      n.pos_n = clamp_n(apb_req.pwdata[CMS_TOOTH_POS_LSB +: 4],
                        CMS_POS_N_MAX);
      n.mem_n = clamp_n(apb_req.pwdata[CMS_TOOTH_MEM_LSB +: 4],
                        CMS_MEM_N_MAX);
      n.slope = apb_req.pwdata[CMS_TOOTH_SLOPE_LSB +: 8];
      n.level = apb_req.pwdata[CMS_TOOTH_LEVEL_LSB +: 8];
    end

    n.rdata = r.rdata;
    if (rd_setup) begin
      n.rdata = '0;
      unique case (apb_req.paddr)
        CMS_ADDR_CTRL: begin
          n.rdata[CMS_CTRL_POL]          = r.polarity;
          n.rdata[CMS_CTRL_HYS_LSB +: 2] = r.hys_sel;
          n.rdata[CMS_CTRL_OPT_LSB +: 2] = r.opt;
          n.rdata[CMS_CTRL_BOUNDED]      = r.bounded;
          n.rdata[CMS_CTRL_AUTO_THR]     = r.auto_thr;
        end
        CMS_ADDR_TOOTH: begin
          n.rdata[CMS_TOOTH_POS_LSB +: 4]   = r.pos_n;
          n.rdata[CMS_TOOTH_MEM_LSB +: 4]   = r.mem_n;
          n.rdata[CMS_TOOTH_SLOPE_LSB +: 8] = r.slope;
          n.rdata[CMS_TOOTH_LEVEL_LSB +: 8] = r.level;
        end
        CMS_ADDR_STATUS: begin
          n.rdata[CMS_STAT_MODE_LSB +: 2]  = r.mode;
          n.rdata[CMS_STAT_TOOTH]          = r.tooth;
          n.rdata[CMS_STAT_OUT]            = r.out_pin;
          n.rdata[CMS_STAT_WRITTEN]        = r.thr_written;
          n.rdata[CMS_STAT_PEAKS_LSB +: 4] = r.peak_cnt;
          n.rdata[CMS_STAT_WDOG_LSB +: 8]  = r.wdog_fires;
        end
        CMS_ADDR_PON_THR: n.rdata[11:0] = r.pon_thr;
        default:      n.rdata = '0;
      endcase
    end

    // factory threshold captured once after reset release
    if (!r.thr_loaded) begin
      n.pon_thr    = nvm_pon_thr;
      n.thr_loaded = 1'b1;
    end

    // calibration always refers to the previous tooth
    pk_idx = (r.mode == CMS_MODE_RUNNING) ? 4'(r.pos_n - 4'h1) : 4'h0;
    pk_ref = r.peaks[pk_idx];
    span   = sat_diff(pk_ref, r.valley);

    // a nonzero slope pulls the level with the span, i.e. the air gap
    dyn_add = frac_of({4'h0, span[11:4]}, r.slope);
    lvl_sum = {1'b0, r.level} + {1'b0, dyn_add[7:0]};
    if (r.slope == 8'h00) begin
      level_use = r.level;
    end else if (lvl_sum > {1'b0, CMS_LEVEL_MAX}) begin
      level_use = CMS_LEVEL_MAX;
    end else begin
      level_use = lvl_sum[7:0];
    end

    thr      = cms_val_t'(r.valley + frac_of(span, level_use));
    half_hys = frac_of(span, hyst_frac(r.hys_sel)) >> 1;
    if (r.mode == CMS_MODE_POWER_ON) begin
      thr      = r.pon_thr;
      half_hys = CMS_STARTUP_HYST >> 1;
    end
    rise_thr = (thr > ~half_hys) ? '1 : cms_val_t'(thr + half_hys);
    fall_thr = sat_diff(thr, half_hys);

    rise_edge = 1'b0;
    fall_edge = 1'b0;
    wdog_fire = 1'b0;
    moving    = sat_diff(r.cur_max, r.cur_min) > CMS_STARTUP_HYST;

    if (sample.valid) begin
      n.cur_max = (s > r.cur_max) ? s : r.cur_max;
      n.cur_min = (s < r.cur_min) ? s : r.cur_min;
      n.po_max  = (s > r.po_max) ? s : r.po_max;
      n.po_min  = (s < r.po_min) ? s : r.po_min;
      if (r.first) begin
        n.first   = 1'b0;
        n.tooth   = s > r.pon_thr;
        n.cur_max = s;
        n.cur_min = s;
        n.po_max  = s;
        n.po_min  = s;
      end else if (!r.tooth && s > rise_thr) begin
        rise_edge = 1'b1;
        n.tooth   = 1'b1;
      end else if (r.tooth && s < fall_thr) begin
        fall_edge = 1'b1;
        n.tooth   = 1'b0;
      end
    end

    if (rise_edge || fall_edge) begin
      n.cur_max  = s;
      n.cur_min  = s;
      n.wdog_cnt = '0;
      n.edge_cnt = (r.edge_cnt == 4'hf) ? r.edge_cnt : 4'(r.edge_cnt + 4'h1);
    end else if (r.mode != CMS_MODE_POWER_ON && r.wdog_cnt != WDOG_LIMIT) begin
      n.wdog_cnt = 25'(r.wdog_cnt + 25'h1);
    end

    // valley ends on a rising edge; bounded mode rejects large jumps
    new_valley = r.cur_min;
    if (rise_edge) begin
      if (r.bounded && r.mode == CMS_MODE_RUNNING
          && ((new_valley > r.valley ? new_valley - r.valley
                                     : r.valley - new_valley)
              > (span >> CMS_BOUND_SHIFT))) begin
        n.valley = r.valley;
      end else begin
        n.valley = new_valley;
      end
    end
    if (fall_edge) begin
      n.peaks    = {r.peaks[11:0], r.cur_max};
      n.peak_cnt = (r.peak_cnt == 4'hf) ? r.peak_cnt
                                        : 4'(r.peak_cnt + 4'h1);
    end

    unique case (r.mode)
      CMS_MODE_POWER_ON: begin
        if (r.opt == CMS_OPT_QUALIFIED) begin
          if (n.edge_cnt >= CMS_QUAL_EDGES) begin
            n.mode = CMS_MODE_RUNNING;
          end
        end else if (r.opt == CMS_OPT_MEMORY) begin
          if (n.peak_cnt >= r.mem_n) begin
            n.mode = CMS_MODE_RUNNING;
          end
        end else if (!r.first
                     && sat_diff(n.po_max, n.po_min) > CMS_STARTUP_HYST) begin
          n.mode     = CMS_MODE_CALIB;
          n.peak_cnt = '0;
        end
        if (n.mode != CMS_MODE_POWER_ON) begin
          // seed the trackers with what power-on already saw
          n.wdog_cnt = '0;
          if (r.peak_cnt == 4'h0 && !fall_edge) begin
            n.peaks[0] = n.po_max;
          end
          if (!rise_edge) begin
            n.valley = n.po_min;
          end
        end
      end
      CMS_MODE_CALIB: begin
        if (n.peak_cnt >= r.pos_n) begin
          n.mode = CMS_MODE_RUNNING;
        end
      end
      CMS_MODE_RUNNING: begin
        n.mode = CMS_MODE_RUNNING;
      end
    endcase

    // learn the installed air gap once running starts; the seeded
    // trackers, not the stale registers, hold the signal midpoint here
    mid = cms_val_t'(n.valley + (sat_diff(n.peaks[0], n.valley) >> 1));
    if (r.mode != CMS_MODE_RUNNING && n.mode == CMS_MODE_RUNNING
        && r.auto_thr && !r.thr_written
        && ((mid > r.pon_thr ? mid - r.pon_thr : r.pon_thr - mid)
            > CMS_THR_DELTA)) begin
      n.pon_thr     = mid;
      n.thr_written = 1'b1;
      n.nvm.strobe  = 1'b1;
      n.nvm.data    = mid;
    end

    // stalled output with live movement: restart from startup hysteresis
    if (r.mode != CMS_MODE_POWER_ON && r.wdog_cnt == WDOG_LIMIT
        && moving) begin
      wdog_fire = 1'b1;
    end
    if (wdog_fire) begin
      n.mode       = CMS_MODE_POWER_ON;
      n.wdog_cnt   = '0;
      n.edge_cnt   = '0;
      n.peak_cnt   = '0;
      n.po_max     = s;
      n.po_min     = s;
      n.cur_max    = s;
      n.cur_min    = s;
      n.wdog_fires = (r.wdog_fires == 8'hff) ? r.wdog_fires
                                             : 8'(r.wdog_fires + 8'h1);
    end

    n.out_pin = r.polarity ? n.tooth : ~n.tooth;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r <= CMS_STATE_RESET;
    end else begin
      r <= n;
    end
  end

endmodule

// >>> test/cms_mode_sequencer_assertions.sv
`timescale 1ns/1ps
module cms_mode_sequencer_assertions
  import cms_pkg::*;
#(
  parameter int WDOG_CYCLES = CMS_WDOG_CYCLES
) (
  input wire logic         ref_clk,
  input wire logic         reset,
  input wire cms_apb_req_t apb_req,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire cms_sample_t  sample,
  input wire cms_val_t     nvm_pon_thr,
  input wire cms_nvm_wr_t  nvm_wr,
  input wire logic         tooth_out
);
  logic       acc;
  logic       wr;
  logic [1:0] n_strobes;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr  = acc && apb_req.pwrite;
  // saturates so a runaway writer still trips the check
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      n_strobes <= 2'h0;
    end else if (nvm_wr.strobe && n_strobes != 2'h3) begin
      n_strobes <= n_strobes + 2'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  apb_ready_a: assert property (pready == acc)
    else $error("pready not tied to access phase");
  slverr_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  bad_read_a: assert property (pslverr && !apb_req.pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mode_legal_a: assert property (acc && !apb_req.pwrite
      && apb_req.paddr == CMS_ADDR_STATUS |-> prdata[1:0] != 2'b10)
    else $error("illegal mode code");
  out_cause_a: assert property ($changed(tooth_out) |->
      $past(sample.valid) || $past(wr) || $past(wr, 2))
    else $error("output moved without sample");
  strobe_pulse_a: assert property (nvm_wr.strobe |=> !nvm_wr.strobe)
    else $error("nvm strobe longer than one cycle");
  strobe_once_a: assert property (n_strobes <= 2'h1)
    else $error("second nvm rewrite");
  nvm_hold_a: assert property ($changed(nvm_wr.data) |-> nvm_wr.strobe)
    else $error("nvm data moved without strobe");
  rdata_hold_a: assert property ($changed(prdata) |->
      $past(apb_req.psel && !apb_req.penable && !apb_req.pwrite))
    else $error("read data moved outside read setup");
endmodule

bind cms_mode_sequencer cms_mode_sequencer_assertions #(
  .WDOG_CYCLES(WDOG_CYCLES)
) u_chk (
  .ref_clk       (ref_clk),
  .reset         (reset),
  .apb_req       (apb_req),
  .prdata        (prdata),
  .pready        (pready),
  .pslverr       (pslverr),
  .sample        (sample),
  .nvm_pon_thr   (nvm_pon_thr),
  .nvm_wr        (nvm_wr),
  .tooth_out     (tooth_out)
);

// >>> test/cms_engine_model.sv
`timescale 1ns/1ps
module cms_engine_model
  import cms_pkg::*;
#(
  parameter cms_val_t FACTORY_THR = 12'h400
) (
  input  wire logic        ref_clk,
  input  wire logic        tooth_out,
  input  wire cms_nvm_wr_t nvm_wr,
  output cms_val_t         nvm_pon_thr,
  output logic [7:0]       n_writes,
  output logic [7:0]       n_edges
);
  logic last_out;
  // no reset port: the store must survive the block's reset
  initial begin
    nvm_pon_thr = FACTORY_THR;
    n_writes = 8'h00;
    n_edges = 8'h00;
    last_out = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (nvm_wr.strobe === 1'b1) begin
      nvm_pon_thr <= nvm_wr.data;
      n_writes <= n_writes + 8'h01;
    end
    last_out <= tooth_out;
    if (tooth_out !== last_out) begin
      n_edges <= n_edges + 8'h01;
    end
  end
endmodule

// >>> test/cms_mode_sequencer_tb.sv
`timescale 1ns/1ps
module cms_mode_sequencer_tb
  import cms_pkg::*;
;
  cms_apb_req_t req;
  cms_sample_t  sample;
  cms_val_t     pon_thr_value;
  cms_nvm_wr_t  nvm_wr;
  logic         ref_clk;
  logic         reset;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         tooth_out;
  logic [7:0]   n_writes;
  logic [7:0]   n_edges;
  logic [31:0]  r;
  logic         e;
  int           miscompares;
  int           n_checks;

  cms_mode_sequencer #(.WDOG_CYCLES(64)) uut (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .apb_req       (req),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sample        (sample),
    .nvm_pon_thr   (pon_thr_value),
    .nvm_wr        (nvm_wr),
    .tooth_out     (tooth_out)
  );
  cms_engine_model partner (
    .ref_clk       (ref_clk),
    .tooth_out     (tooth_out),
    .nvm_wr        (nvm_wr),
    .nvm_pon_thr   (pon_thr_value),
    .n_writes      (n_writes),
    .n_edges       (n_edges)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    req <= '0;
    if (k == 16) begin
      miscompares++;
      $display("BAD %0t no pready", $time);
      print_verdict();
    end
  endtask

  task automatic mode_is(input logic [1:0] m);
    apb(1'b0, CMS_ADDR_STATUS, 32'h0);
    chk({30'h0, r[1:0]}, {30'h0, m});
  endtask

  // value is kept after the pulse; only valid qualifies it
  task automatic smp(input cms_val_t v);
    @(posedge ref_clk);
    sample <= '{valid: 1'b1, value: v};
    @(posedge ref_clk);
    sample.valid <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic sc_regs();
    int i;
    do_reset();
    apb(1'b0, CMS_ADDR_CTRL, 32'h0);
    chk(r, 32'h41);
    apb(1'b0, CMS_ADDR_TOOTH, 32'h0);
    chk(r, 32'h00800011);
    apb(1'b1, CMS_ADDR_PON_THR, 32'h123);
    apb(1'b0, CMS_ADDR_PON_THR, 32'h0);
    chk(r, 32'h400);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, CMS_ADDR_CTRL, {29'h0, i[1:0], 1'b0} | 32'h41);
      apb(1'b0, CMS_ADDR_CTRL, 32'h0);
      chk(r, {29'h0, i[1:0], 1'b0} | 32'h41);
    end
    apb(1'b1, CMS_ADDR_TOOTH, 32'h0);
    apb(1'b0, CMS_ADDR_TOOTH, 32'h0);
    chk(r, 32'h11);
    apb(1'b1, CMS_ADDR_TOOTH, 32'hffffffff);
    apb(1'b0, CMS_ADDR_TOOTH, 32'h0);
    chk(r, 32'hffffcd);
  endtask

  task automatic sc_rapid();
    do_reset();
    smp(12'h300);
    chk({31'h0, tooth_out}, 32'h0);
    smp(12'h330);
    mode_is(2'b00);
    smp(12'h350);
    mode_is(2'b01);
    apb(1'b1, CMS_ADDR_CTRL, 32'h40);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({31'h0, tooth_out}, 32'h1);
  endtask

  task automatic sc_qual();
    logic [7:0] e0;
    do_reset();
    apb(1'b1, CMS_ADDR_CTRL, 32'h49);
    smp(12'h3a0);
    e0 = n_edges;
    smp(12'h410);
    chk({31'h0, tooth_out}, 32'h0);
    smp(12'h6f0);
    chk({31'h0, tooth_out}, 32'h1);
    mode_is(2'b00);
    smp(12'h3a0);
    mode_is(2'b11);
    chk({24'h0, n_edges - e0}, 32'h2);
    chk({24'h0, n_writes}, 32'h1);
    chk({20'h0, nvm_wr.data}, 32'h548);
    // moves below the rising threshold: output stalls, movement stays
    repeat (6) begin
      smp(12'h570);
      smp(12'h500);
    end
    repeat (100) @(posedge ref_clk);
    mode_is(2'b00);
    chk({24'h0, r[23:16]}, 32'h1);
  endtask

  task automatic sc_memory();
    do_reset();
    apb(1'b0, CMS_ADDR_PON_THR, 32'h0);
    chk(r, 32'h548);
    apb(1'b1, CMS_ADDR_TOOTH, 32'h8021);
    apb(1'b1, CMS_ADDR_CTRL, 32'h51);
    smp(12'h3a0);
    smp(12'h6f0);
    smp(12'h3a0);
    mode_is(2'b00);
    smp(12'h6f0);
    smp(12'h3a0);
    mode_is(2'b11);
    chk({24'h0, n_writes}, 32'h1);
  endtask

  initial begin
    reset = 1'b1;
    req = '0;
    sample = '0;
    miscompares = 0;
    n_checks = 0;
    sc_regs();
    sc_rapid();
    sc_qual();
    sc_memory();
    print_verdict();
  end
endmodule
